// ---- iacp_host_model.sv ----
/*
  host acknowledge logic and upstream chain neighbour for the port.
  assumes the bench sets the strobe and the enable levels at the falling edge.
*/
`timescale 1ns/1ps
module iacp_host_model
  import iacp_pkg::*;
(
  input wire logic ack_go,
  input wire logic [1:0] sel_addr,
  input wire logic a_o,
  input wire logic a_oe,
  input wire logic b_o,
  input wire logic b_oe,
  output logic strobe,
  output logic pin_a,
  output logic pin_b
);
  // acknowledge cycle follows the bench request at once
  assign strobe = ack_go;
  // pin a: port drives in daisy mode, host drives the address bit otherwise
  assign pin_a = a_oe ? a_o : sel_addr[0];
  // pin b: upstream drives it high to pass priority
  assign pin_b = b_oe ? b_o : sel_addr[1];
endmodule // iacp_host_model

// ---- iacp_irq_stage.sv ----
/*
  interrupt request output stage: open drain, push-pull active low or
  push-pull active high, chosen by two configuration bits.
  assumes the board pulls the open-drain line high.
*/
`timescale 1ns/1ps
module iacp_irq_stage
  import iacp_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic irq_req,
  input wire logic irq_output_cfg_hi,
  input wire logic irq_output_cfg_lo,
  output iacp_pin_t irq_pin
);
  iacp_irq_st_t st_r;
  iacp_irq_st_t st_nxt;

  // output stage selection from the two configuration bits
  always_comb begin
    st_nxt = st_r;
    if (!irq_output_cfg_lo) begin
      st_nxt.pin.o = 1'b0;
      st_nxt.pin.oe = irq_req; // open drain only pulls low
    end else if (!irq_output_cfg_hi) begin
      st_nxt.pin.o = !irq_req;
      st_nxt.pin.oe = 1'b1;
    end else begin
      st_nxt.pin.o = irq_req;
      st_nxt.pin.oe = 1'b1;
    end
  end

  // registered so the pin never glitches on a config change
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign irq_pin = st_r.pin;

  a_od_no_drive: assert property (@(posedge mclk) disable iff (!rstn)
    !irq_output_cfg_lo && !irq_req |=> !irq_pin.oe)
    else $error("open drain drives while idle");
  a_pp_low_level: assert property (@(posedge mclk) disable iff (!rstn)
    irq_output_cfg_lo && !irq_output_cfg_hi |=> irq_pin.oe && (irq_pin.o == !$past(irq_req)))
    else $error("push-pull low level wrong");
  a_pp_high_level: assert property (@(posedge mclk) disable iff (!rstn)
    irq_output_cfg_lo && irq_output_cfg_hi |=> irq_pin.oe && (irq_pin.o == $past(irq_req)))
    else $error("push-pull high level wrong");
  // open drain must actually pull the line low while a request stands
  a_od_pull_low: assert property (@(posedge mclk) disable iff (!rstn)
    !irq_output_cfg_lo && irq_req |=> irq_pin.oe && !irq_pin.o)
    else $error("open drain does not pull low");

  c_pp_high: cover property (@(posedge mclk) disable iff (!rstn)
    irq_output_cfg_lo && irq_output_cfg_hi && irq_pin.o);
endmodule // iacp_irq_stage

// ---- iacp_map.svh ----
/*
  constants for the interrupt acknowledge cascade port: configuration
  field positions, reset values and the acknowledge timing count.
  assumes inclusion by bare name from package and modules.
*/
`ifndef IACP_MAP_SVH
`define IACP_MAP_SVH

// interrupt port configuration field positions
`define IACP_CFG_IC_LO 0
`define IACP_CFG_IC_HI 1
`define IACP_CFG_CASCADE_MODE_SELECT 2
`define IACP_CFG_SLA_LO 3
`define IACP_CFG_SLA_HI 4
`define IACP_CFG_WIDTH 5
// reset value of the configuration: open drain, slave cascading, address 0
`define IACP_CFG_RESET 5'h00
// cascade mode codes
`define IACP_MODE_SLAVE 1'b0
`define IACP_MODE_DAISY 1'b1
// clock period in ps and least acknowledge hold time in ns
`define IACP_MCLK_PS 25000
`define IACP_ACK_MIN_NS 25
`define IACP_ACK_MIN_CYC (((`IACP_ACK_MIN_NS * 1000) + `IACP_MCLK_PS - 1) / `IACP_MCLK_PS)

`endif

// ---- iacp_pkg.sv ----
/*
  types for the interrupt acknowledge cascade port.
  assumes iacp_map.svh is on the include path.
*/
package iacp_pkg;
  `include "iacp_map.svh"

  // acknowledge handling states, gray along idle-pending-granted-done
  typedef enum logic [1:0] {
    IACP_IDLE = 2'b00,
    IACP_PEND = 2'b01,
    IACP_GRANT = 2'b11,
    IACP_DONE = 2'b10
  } iacp_state_t;

  // configuration bundle as seen by the port
  typedef struct packed {
    logic slave_addr_hi;
    logic slave_addr_lo;
    logic cascade_mode_select;
    logic irq_output_cfg_hi;
    logic irq_output_cfg_lo;
  } iacp_cfg_t;

  // interrupt request output stage, two signals of the pin
  typedef struct packed {
    logic o;
    logic oe;
  } iacp_pin_t;

  // state of the irq output stage module
  typedef struct packed {
    iacp_pin_t pin;
  } iacp_irq_st_t;

  // state of the top module
  typedef struct packed {
    iacp_state_t state;
    logic ack_accept;
    logic pin_a_o;
    logic pin_a_oe;
  } iacp_top_st_t;
endpackage

// ---- iacp_port.sv ----
/*
  interrupt acknowledge cascade port: accepts an acknowledge in slave
  cascading or daisy chaining mode and drives the interrupt request pin.
  assumes irq_req comes from the surrounding controller and all inputs
  are synchronous to mclk.
*/
// Summary of operation
// - slave cascading: both enable pins are inputs only
// - slave ack needs request and address match
// - daisy mode: pin a drives, pin b samples
// - daisy ack needs request and chain input high
// - low cfg bit selects open drain or push-pull low
// - both cfg bits set: push-pull active high
`timescale 1ns/1ps
module iacp_port
  import iacp_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire iacp_cfg_t interrupt_port_config,
  input wire logic irq_req,
  input wire logic interrupt_ack_strobe,
  input wire logic chain_enable_pin_a_i,
  output logic chain_enable_pin_a_o,
  output logic chain_enable_pin_a_oe,
  input wire logic chain_enable_pin_b_i,
  output logic chain_enable_pin_b_o,
  output logic chain_enable_pin_b_oe,
  output logic irq_pin_o,
  output logic irq_pin_oe,
  output logic ack_accept,
  output logic ack_busy
);
  iacp_top_st_t st_r;
  iacp_top_st_t st_nxt;
  iacp_pin_t irq_pin;
  logic daisy;
  logic addr_match;
  logic ack_ok;
  logic ack_rise;
  logic ack_d_r;

  assign daisy = (interrupt_port_config.cascade_mode_select == `IACP_MODE_DAISY);
  // slave address compare against the two enable inputs
  assign addr_match = (chain_enable_pin_a_i == interrupt_port_config.slave_addr_lo) &&
                      (chain_enable_pin_b_i == interrupt_port_config.slave_addr_hi);
  // acknowledge qualification for each mode
  assign ack_ok = daisy ? chain_enable_pin_b_i : addr_match;
  assign ack_rise = interrupt_ack_strobe && !ack_d_r;

  // edge detector on the acknowledge strobe
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ack_d_r <= 1'b0;
    end else begin
      ack_d_r <= interrupt_ack_strobe;
    end
  end

  // acknowledge sequencing and chain enable pin
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack_accept = 1'b0;
    unique case (st_r.state)
      IACP_IDLE: begin
        if (irq_req) begin
          st_nxt.state = IACP_PEND;
        end
      end
      IACP_PEND: begin
        if (!irq_req) begin
          st_nxt.state = IACP_IDLE;
        end else if (ack_rise && ack_ok) begin
          st_nxt.state = IACP_GRANT;
          st_nxt.ack_accept = 1'b1;
        end
      end
      IACP_GRANT: begin
        st_nxt.state = IACP_DONE;
      end
      IACP_DONE: begin
        if (!interrupt_ack_strobe) begin
          st_nxt.state = IACP_IDLE;
        end
      end
    endcase
    // chain enable out passes priority only when we have no request
    st_nxt.pin_a_oe = daisy;
    st_nxt.pin_a_o = daisy && chain_enable_pin_b_i && !irq_req;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // request gates the chain output combinationally, no cycle of delay
  assign chain_enable_pin_a_o = st_r.pin_a_o && !irq_req;
  // gated by the live mode bit so a switch to slave mode releases pin a at once
  assign chain_enable_pin_a_oe = st_r.pin_a_oe && daisy;
  // pin b is never driven in either mode
  assign chain_enable_pin_b_o = 1'b0;
  assign chain_enable_pin_b_oe = 1'b0;
  assign ack_accept = st_r.ack_accept;
  assign ack_busy = (st_r.state != IACP_IDLE);

  iacp_irq_stage u_irq (
    .mclk(mclk),
    .rstn(rstn),
    .irq_req(irq_req),
    .irq_output_cfg_hi(interrupt_port_config.irq_output_cfg_hi),
    .irq_output_cfg_lo(interrupt_port_config.irq_output_cfg_lo),
    .irq_pin(irq_pin)
  );
  assign irq_pin_o = irq_pin.o;
  assign irq_pin_oe = irq_pin.oe;

  a_slave_no_drive: assert property (@(posedge mclk) disable iff (!rstn)
    !daisy |-> !chain_enable_pin_a_oe && !chain_enable_pin_b_oe)
    else $error("enable pin driven in slave mode");
  a_slave_ack_match: assert property (@(posedge mclk) disable iff (!rstn)
    ack_accept && !$past(daisy) |-> $past(addr_match) && $past(irq_req))
    else $error("slave ack without address match");
  a_daisy_pin_dir: assert property (@(posedge mclk) disable iff (!rstn)
    daisy && $past(daisy) |-> chain_enable_pin_a_oe && !chain_enable_pin_b_oe)
    else $error("daisy pin direction wrong");
  a_daisy_ack_chain: assert property (@(posedge mclk) disable iff (!rstn)
    ack_accept && $past(daisy) |-> $past(chain_enable_pin_b_i) && $past(irq_req))
    else $error("daisy ack without chain input");
  a_ack_one_cycle: assert property (@(posedge mclk) disable iff (!rstn)
    ack_accept |=> !ack_accept)
    else $error("ack accept longer than one cycle");
  a_chain_block: assert property (@(posedge mclk) disable iff (!rstn)
    irq_req |-> !chain_enable_pin_a_o)
    else $error("chain enable high during request");
  a_chain_pass: assert property (@(posedge mclk) disable iff (!rstn)
    daisy && chain_enable_pin_b_i && !irq_req ##1 daisy && !irq_req |-> chain_enable_pin_a_o)
    else $error("chain enable not passed");
  // no request at the deciding edge means no accept pulse after it
  a_ack_needs_req: assert property (@(posedge mclk) disable iff (!rstn)
    !$past(irq_req) |-> !ack_accept)
    else $error("ack accepted without request");
  // a held strobe must not be accepted twice; only a rising strobe counts
  a_ack_on_rise: assert property (@(posedge mclk) disable iff (!rstn)
    ack_accept |-> $past(interrupt_ack_strobe) && !$past(interrupt_ack_strobe, 2))
    else $error("ack accepted without strobe rise");

  c_slave_ack: cover property (@(posedge mclk) disable iff (!rstn) ack_accept && !daisy);
  c_daisy_ack: cover property (@(posedge mclk) disable iff (!rstn) ack_accept && daisy);
  c_chain_pass: cover property (@(posedge mclk) disable iff (!rstn) chain_enable_pin_a_o);
  c_chain_block: cover property (@(posedge mclk) disable iff (!rstn)
    daisy && chain_enable_pin_b_i && irq_req);
endmodule // iacp_port

// ---- iacp_port_bench.sv ----
/*
  self-checking bench for the interrupt acknowledge cascade port.
  assumes iacp_map.svh on the include path and the host model beside it.
*/
`timescale 1ns/1ps
module iacp_port_bench;
  import iacp_pkg::*;
  logic mclk = 1'h0;
  logic rstn = 1'h0;
  iacp_cfg_t cfg = 5'h00;
  logic irq_req = 1'h0;
  logic ack_go = 1'h0;
  logic [1:0] sel_addr = 2'h0;
  logic strobe, pin_a, pin_b, a_o, a_oe, b_o, b_oe, irq_o, irq_oe, acc, busy;
  int n_errors = 0;
  int num_checks = 0;
  int hits;
  always #12.5 mclk = ~mclk;
  iacp_host_model host_u (.ack_go(ack_go), .sel_addr(sel_addr), .a_o(a_o), .a_oe(a_oe),
    .b_o(b_o), .b_oe(b_oe), .strobe(strobe), .pin_a(pin_a), .pin_b(pin_b));
  iacp_port dut_u (.mclk(mclk), .rstn(rstn), .interrupt_port_config(cfg), .irq_req(irq_req),
    .interrupt_ack_strobe(strobe), .chain_enable_pin_a_i(pin_a), .chain_enable_pin_a_o(a_o),
    .chain_enable_pin_a_oe(a_oe), .chain_enable_pin_b_i(pin_b), .chain_enable_pin_b_o(b_o),
    .chain_enable_pin_b_oe(b_oe), .irq_pin_o(irq_o), .irq_pin_oe(irq_oe),
    .ack_accept(acc), .ack_busy(busy));
  task automatic chk(input string what, input logic [1:0] seen, input logic [1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one acknowledge attempt; counting pulses catches both a miss and a repeat
  task automatic ack(input logic req, input logic exp);
    irq_req = req;
    repeat (2) @(negedge mclk);
    ack_go = 1'h1;
    hits = 0;
    repeat (4) begin
      @(negedge mclk);
      hits += int'(acc === 1'h1);
    end
    chk("ack_accept", 2'(hits), {1'h0, exp});
    chk("ack_busy", {1'h0, busy}, {1'h0, req});
    ack_go = 1'h0;
    irq_req = 1'h0;
    repeat (3) @(negedge mclk);
    chk("ack_idle", {1'h0, busy}, 2'h0);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (6) @(negedge mclk);
    chk("reset_outs", {irq_oe, acc}, 2'h0);
    rstn = 1'h1;
    @(negedge mclk);
    // output stage: every code with request low and high
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 2; r++) begin
        cfg = 5'(c);
        irq_req = r[0];
        repeat (2) @(negedge mclk);
        chk("irq_pin", {irq_o, irq_oe}, c[0] ? {~(c[1] ^ r[0]), 1'h1} : {1'h0, r[0]});
      end
    end
    irq_req = 1'h0;
    $display("test output_stage done");
    // slave cascading: each address matched, then each bit wrong
    for (int a = 0; a < 4; a++) begin
      cfg = {a[1], a[0], 3'h0};
      sel_addr = 2'(a);
      ack(1'h1, 1'h1);
      chk("pin_oe", {a_oe, b_oe}, 2'h0);
      chk("pin_b", {b_o, b_oe}, 2'h0);
      sel_addr = 2'(a) ^ 2'h1;
      ack(1'h1, 1'h0);
      sel_addr = 2'(a) ^ 2'h2;
      ack(1'h1, 1'h0);
    end
    sel_addr = 2'h3;
    ack(1'h0, 1'h0);
    $display("test slave_cascade done");
    // daisy chain: enable passes through until a request blocks it
    cfg = 5'h04;
    sel_addr = 2'h0;
    repeat (2) @(negedge mclk);
    chk("chain_out", {a_oe, a_o}, 2'h2);
    sel_addr = 2'h2;
    repeat (2) @(negedge mclk);
    chk("chain_out", {a_oe, a_o}, 2'h3);
    chk("pin_b_oe", {1'h0, b_oe}, 2'h0);
    irq_req = 1'h1;
    #1;
    chk("chain_block", {1'h0, a_o}, 2'h0);
    ack(1'h1, 1'h1);
    sel_addr = 2'h0;
    ack(1'h1, 1'h0);
    sel_addr = 2'h2;
    ack(1'h0, 1'h0);
    $display("test daisy_chain done");
    end_of_test();
  end
  // watchdog: the tests need about 170 cycles, allow over twenty times that
  initial begin
    #(4000 * 25);
    n_errors++;
    end_of_test();
  end
endmodule // iacp_port_bench
